// ---- hdl/sdram_cmd_pkg.sv ----
// shared types and constants for the sdram command decoder
package sdram_cmd_pkg;

	localparam int NUM_BANKS = 4;
	localparam int BANK_W    = 2;

	// command codes presented to the core
	typedef enum logic [3:0] {
		CMD_NOP       = 4'h0,
		CMD_ACTIVATE  = 4'h1,
		CMD_PRECHARGE = 4'h2,
		CMD_PRE_ALL   = 4'h3,
		CMD_WRITE     = 4'h4,
		CMD_WRITE_AP  = 4'h5,
		CMD_READ      = 4'h6,
		CMD_READ_AP   = 4'h7,
		CMD_MODE_SET  = 4'h8,
		CMD_BURST_STOP = 4'h9,
		CMD_AUTO_REF  = 4'ha,
		CMD_SELF_REF  = 4'hb
	} cmd_e;

	// clock-enable state of the device
	typedef enum logic [1:0] {
		ST_RUN      = 2'b00,
		ST_SUSPEND  = 2'b01,
		ST_POWER_DN = 2'b10,
		ST_SELF_REF = 2'b11
	} mode_e;

	// sampled command pins, active-low strobes
	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic              a10;
		logic [BANK_W-1:0] bank;
	} pins_s;

	// decoded command handed to the core
	typedef struct packed {
		logic              valid;
		cmd_e              cmd;
		logic [BANK_W-1:0] bank;
	} dec_s;

	localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 4'h0;
	localparam logic [NUM_BANKS-1:0] BANKS_ALL  = 4'hf;

endpackage : sdram_cmd_pkg

// ---- hdl/sdram_bank_state.sv ----
// per-bank open/closed state store with registered read data
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_state
	import sdram_cmd_pkg::*;
#(
	parameter int NB = NUM_BANKS
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          en,
	input  wire logic [NB-1:0] open_set,
	input  wire logic [NB-1:0] close_set,
	output logic      [NB-1:0] open_q
);
	// set wins over close when both arrive in one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_q <= '0;
		end else if (en) begin
			open_q <= (open_q & ~close_set) | open_set;
		end
	end
endmodule : sdram_bank_state
`default_nettype wire

// ---- hdl/sdram_command_decode.sv ----
// command decoder and clock-enable state control for a four-bank sdram
// Notes on behaviour
// [RQ1] cs low, ras cas we high decodes no-operation.
// [RQ2] no-operation leaves a running burst untouched.
// [RQ3] controller sends no-operations while idle or waiting.
// [RQ4] cs high is deselect, same as no-operation, strobes ignored.
// [RQ5] controller holds clock enable high during normal accesses.
// [RQ6] clock enable low with a bank active enters clock suspend.
// [RQ7] suspend takes effect one clock after clock enable registered low.
// [RQ8] commands presented during clock suspend are ignored.
// [RQ9] suspend ends one clock after clock enable registered high again.
// [RQ10] commands are latched on rising clock edges only.
// [RQ11] activate on idle bank, precharge one or all by a10, mode set idle.
// [RQ12] read or write on active selected bank; we picks; a10 adds auto-precharge.
// [RQ13] burst stop is cs we low, valid only during full-page burst.
// [RQ14] idle refresh pattern: auto-refresh, or self-refresh entry if cke falls.
// [RQ15] cke falling while idle with nop or deselect enters power down.
// [RQ16] power-down pattern during a burst enters clock suspend instead.
// [RQ17] power down exits on cke rising with nop or deselect.
// [RQ18] with a bank active, cke edges enter and leave suspend regardless.
// [RQ19] decode uses current and previous cke; commands need previous high.
// [RQ20] controller issues no-operation on the edge after power-down exit.
// [RQ21] self refresh ignores all inputs but cke and gates internal clock; the code also needs nop or deselect with cke rising to exit.
// [RQ22] registered lookup decode; unassigned patterns become no-operation.
`timescale 1ns/1ps
`default_nettype none
module sdram_command_decode
	import sdram_cmd_pkg::*;
#(
	parameter int NB = NUM_BANKS
) (
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic              a10,
	input  wire logic              bank_sel_lo,
	input  wire logic              bank_sel_hi,
	input  wire logic              cke,
	input  wire logic              burst_active,
	input  wire logic              full_page,
	output logic                   cmd_valid,
	output cmd_e                   cmd_code,
	output logic      [BANK_W-1:0] cmd_bank,
	output logic                   cmd_auto_pre,
	output logic                   int_clk_en,
	output mode_e                  mode,
	output logic      [NB-1:0]     bank_open
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	pins_s pins;
	logic  prev_clk_enable_level_q;
	logic  curr_clk_enable_level;
	mode_e mode_q;
	mode_e mode_d;
	logic  gate_q;
	logic  gate_d;

	assign pins = '{cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
		a10: a10, bank: {bank_sel_hi, bank_sel_lo}};
	assign curr_clk_enable_level = cke;

	// cke history sampled every rising edge with clk_en high, even while suspended
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prev_clk_enable_level_q <= 1'b1;
		end else if (clk_en) begin
			prev_clk_enable_level_q <= curr_clk_enable_level; // see [RQ10] see [RQ19]
		end
	end

	// ----------------------------------------
	// combinational lookup
	// ----------------------------------------
	function automatic cmd_e lookup(input pins_s p, input logic cke_now);
		cmd_e c;
		c = CMD_NOP;
		if (!p.cs_n) begin // see [RQ4]
			case ({p.ras_n, p.cas_n, p.we_n})
				3'b111:  c = CMD_NOP; // see [RQ1]
				3'b011:  c = CMD_ACTIVATE; // see [RQ11]
				3'b010:  c = p.a10 ? CMD_PRE_ALL : CMD_PRECHARGE; // see [RQ11]
				3'b000:  c = CMD_MODE_SET; // see [RQ11]
				3'b100:  c = p.a10 ? CMD_WRITE_AP : CMD_WRITE; // see [RQ12]
				3'b101:  c = p.a10 ? CMD_READ_AP : CMD_READ; // see [RQ12]
				3'b110:  c = CMD_BURST_STOP; // see [RQ13]
				3'b001:  c = cke_now ? CMD_AUTO_REF : CMD_SELF_REF; // see [RQ14]
				default: c = CMD_NOP; // see [RQ22]
			endcase
		end
		return c;
	endfunction : lookup

	function automatic logic is_nop(input pins_s p);
		return p.cs_n | (p.ras_n & p.cas_n & p.we_n);
	endfunction : is_nop

	// ----------------------------------------
	// state legality
	// ----------------------------------------
	logic [NB-1:0] open_q;
	cmd_e          raw_cmd;
	logic          any_open;
	logic          sel_open;
	logic          legal;
	logic          accept;
	logic          nop_pat;
	logic          cke_fall;
	logic          cke_rise;

	assign raw_cmd  = lookup(pins, curr_clk_enable_level);
	assign any_open = |open_q;
	assign sel_open = open_q[pins.bank];
	assign nop_pat  = is_nop(pins);
	assign cke_fall = prev_clk_enable_level_q & ~curr_clk_enable_level;
	assign cke_rise = ~prev_clk_enable_level_q & curr_clk_enable_level;

	// ----------------------------------------
	// command classes
	// ----------------------------------------
	logic is_act;
	logic is_mode_set;
	logic is_rw;
	logic is_ap_rw;
	logic is_stop;
	logic is_ref;

	assign is_act      = (raw_cmd == CMD_ACTIVATE);
	assign is_mode_set = (raw_cmd == CMD_MODE_SET);
	assign is_ap_rw    = (raw_cmd == CMD_READ_AP) || (raw_cmd == CMD_WRITE_AP);
	assign is_rw       = (raw_cmd == CMD_READ) || (raw_cmd == CMD_WRITE) || is_ap_rw;
	assign is_stop     = (raw_cmd == CMD_BURST_STOP);
	assign is_ref      = (raw_cmd == CMD_AUTO_REF) || (raw_cmd == CMD_SELF_REF);

	// unsupported-state commands are dropped rather than corrupting bank state
	assign legal =
		is_act      ? ~sel_open : // see [RQ11]
		is_mode_set ? ~any_open : // see [RQ11]
		is_rw       ? sel_open : // see [RQ12]
		is_stop     ? (burst_active & full_page) : // see [RQ13]
		is_ref      ? ~any_open : // see [RQ14]
		1'b1;

	// commands only in run mode with previous cke high; suspend and self refresh ignore them
	assign accept = (mode_q == ST_RUN) && prev_clk_enable_level_q && legal
		&& (raw_cmd != CMD_NOP); // see [RQ8] see [RQ19] see [RQ21] see [RQ2]

	// ----------------------------------------
	// mode transition triggers
	// ----------------------------------------
	logic sref_go;
	logic susp_go;
	logic pdn_go;
	logic wake_ok;

	assign sref_go = accept && (raw_cmd == CMD_SELF_REF);
	// a running burst forces suspend even with no bank open, unless a self-refresh entry is accepted
	assign susp_go = cke_fall && (any_open || burst_active);
	assign pdn_go  = cke_fall && nop_pat;
	assign wake_ok = cke_rise && nop_pat;

	// ----------------------------------------
	// cke mode machine
	// ----------------------------------------
	always_comb begin
		mode_d = mode_q;
		gate_d = gate_q;
		case (mode_q)
			ST_RUN: begin
				gate_d = 1'b1;
				if (sref_go) begin
					mode_d = ST_SELF_REF; // see [RQ14]
					gate_d = 1'b0; // see [RQ21]
				end else if (susp_go) begin
					mode_d = ST_SUSPEND; // see [RQ6] see [RQ16] see [RQ18]
				end else if (pdn_go) begin
					mode_d = ST_POWER_DN; // see [RQ15]
				end
			end
			ST_SUSPEND: begin
				gate_d = 1'b0; // see [RQ7]
				if (cke_rise) begin
					mode_d = ST_RUN; // see [RQ9] see [RQ18]
				end
			end
			ST_POWER_DN: begin
				gate_d = 1'b0;
				if (wake_ok) begin
					mode_d = ST_RUN; // see [RQ17]
				end
			end
			ST_SELF_REF: begin
				gate_d = 1'b0;
				if (wake_ok) begin
					mode_d = ST_RUN; // see [RQ14] see [RQ21]
				end
			end
			default: begin
				mode_d = ST_RUN;
				gate_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= ST_RUN;
			gate_q <= 1'b1;
		end else if (clk_en) begin
			mode_q <= mode_d;
			gate_q <= gate_d;
		end
	end

	// ----------------------------------------
	// bank open tracking
	// ----------------------------------------
	logic [NB-1:0] open_set;
	logic [NB-1:0] close_set;
	logic [NB-1:0] sel_mask;

	assign sel_mask  = NB'(1) << pins.bank;
	assign open_set  = (accept && raw_cmd == CMD_ACTIVATE) ? sel_mask : '0; // see [RQ11]
	// auto-precharge closes the bank at command time; burst timing lives elsewhere
	assign close_set =
		(accept && raw_cmd == CMD_PRE_ALL) ? BANKS_ALL : // see [RQ11]
		(accept && (raw_cmd == CMD_PRECHARGE || is_ap_rw)) ? sel_mask : BANKS_IDLE; // see [RQ12]

	sdram_bank_state #(
		.NB (NB)
	) u_banks (
		.clk       (core_clk),
		.rst_n     (rst_n_q),
		.en        (clk_en),
		.open_set  (open_set),
		.close_set (close_set),
		.open_q    (open_q)
	);

	// ----------------------------------------
	// registered command output
	// ----------------------------------------
	dec_s dec_q;

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dec_q <= '{valid: 1'b0, cmd: CMD_NOP, bank: '0};
		end else if (clk_en) begin
			dec_q <= '{valid: accept, cmd: accept ? raw_cmd : CMD_NOP,
				bank: pins.bank}; // see [RQ22] see [RQ10]
		end
	end

	logic auto_pre_q;

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			auto_pre_q <= 1'b0;
		end else if (clk_en) begin
			auto_pre_q <= accept & is_ap_rw; // see [RQ12]
		end
	end

	assign cmd_valid    = dec_q.valid;
	assign cmd_code     = dec_q.cmd;
	assign cmd_bank     = dec_q.bank;
	assign cmd_auto_pre = auto_pre_q & ~(dec_q.cmd == CMD_PRE_ALL);
	assign int_clk_en   = gate_q;
	assign mode         = mode_q;
	assign bank_open    = open_q;

endmodule : sdram_command_decode
`default_nettype wire

// ---- testbench/sdram_command_decode_chk.sv ----
// assertions on the sdram command decoder ports
`timescale 1ns/1ps
`default_nettype none
module sdram_command_decode_chk
	import sdram_cmd_pkg::*;
#(parameter int NB = NUM_BANKS) (
	input wire logic          core_clk,
	input wire logic          arst_n,
	input wire logic          cs_n,
	input wire logic          ras_n,
	input wire logic          cas_n,
	input wire logic          we_n,
	input wire logic          cke,
	input wire logic          burst_active,
	input wire logic          cmd_valid,
	input wire logic          int_clk_en,
	input wire mode_e         mode,
	input wire logic [NB-1:0] bank_open
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// nop or deselect on the strobes
	wire idle_w = cs_n || (ras_n && cas_n && we_n);
	sequence s_fall;
		$past(cke) && !cke;
	endsequence
	sequence s_wake;
		mode == ST_RUN ##1 int_clk_en;
	endsequence
	chk_nop_quiet: assert property (!cs_n && ras_n && cas_n && we_n |=> !cmd_valid)
		else $error("no-op gave a command");
	chk_prev_low: assert property (!$past(cke) |=> !cmd_valid)
		else $error("command taken after low clock enable");
	chk_susp_entry: assert property (s_fall ##0 (mode == ST_RUN && bank_open != '0)
		|=> mode == ST_SUSPEND) else $error("no suspend entry");
	chk_susp_delay: assert property ($rose(mode == ST_SUSPEND) && !cke
		|-> int_clk_en ##1 !int_clk_en) else $error("suspend gating mistimed");
	chk_susp_ignore: assert property (mode == ST_SUSPEND |=> !cmd_valid)
		else $error("command taken in suspend");
	chk_susp_exit: assert property (mode == ST_SUSPEND && cke |=> s_wake)
		else $error("suspend exit mistimed");
	chk_pdn_entry: assert property (s_fall ##0 (mode == ST_RUN && bank_open == '0
		&& !burst_active && idle_w) |=> mode == ST_POWER_DN) else $error("no power down");
	chk_pdn_burst: assert property (s_fall ##0 (mode == ST_RUN && bank_open == '0
		&& burst_active && idle_w) |=> mode == ST_SUSPEND) else $error("burst not suspended");
	chk_pdn_exit: assert property (mode == ST_POWER_DN && cke && idle_w |=> mode == ST_RUN)
		else $error("power down exit missed");
	chk_sref_hold: assert property (mode == ST_SELF_REF && !cke
		|=> mode == ST_SELF_REF && !cmd_valid) else $error("self refresh left early");
endmodule : sdram_command_decode_chk
bind sdram_command_decode sdram_command_decode_chk #(.NB(NB)) chk (
	.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
	.we_n(we_n), .cke(cke), .burst_active(burst_active), .cmd_valid(cmd_valid),
	.int_clk_en(int_clk_en), .mode(mode), .bank_open(bank_open));
`default_nettype wire

// ---- testbench/sdram_ctrl_model.sv ----
// memory controller model that drives the command pins
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
	import sdram_cmd_pkg::*;
(
	input  wire logic core_clk,
	output var pins_s pins,
	output logic      cke
);
	// idle pins carry a no-op, never a stray command
	initial pins = 7'h38;
	initial cke = 1'b1;
	// pins move at the falling edge, clear of sampling
	task automatic send(input logic [6:0] p, input logic k);
		@(negedge core_clk);
		pins = p;
		cke = k;
	endtask : send
endmodule : sdram_ctrl_model
`default_nettype wire

// ---- testbench/test_sdram_command_decode.sv ----
// self-checking bench for the sdram command decoder
`timescale 1ns/1ps
`default_nettype none
module test_sdram_command_decode
	import sdram_cmd_pkg::*;
;
	logic       core_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       burst_active = 1'b0;
	logic       full_page = 1'b0;
	pins_s      pins;
	logic       cke;
	logic       cmd_valid;
	cmd_e       cmd_code;
	logic [1:0] cmd_bank;
	logic       cmd_auto_pre;
	logic       int_clk_en;
	mode_e      mode;
	logic [3:0] bank_open;
	logic [3:0] bo = 4'h0;
	int         mismatches = 0;
	int         tests_run = 0;
	int         cycles = 0;

	always #12.5 core_clk = ~core_clk;
	sdram_ctrl_model ctrl (.core_clk(core_clk), .pins(pins), .cke(cke));
	sdram_command_decode dut (
		.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .cs_n(pins.cs_n),
		.ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .a10(pins.a10),
		.bank_sel_lo(pins.bank[0]), .bank_sel_hi(pins.bank[1]), .cke(cke),
		.burst_active(burst_active), .full_page(full_page), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_auto_pre(cmd_auto_pre),
		.int_clk_en(int_clk_en),
		.mode(mode), .bank_open(bank_open));

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// a hung handshake must not stall the run
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 500) begin
			mismatches++;
			final_report();
		end
	end

	// top two bits carry burst_active and full_page
	task automatic cyc(input logic [8:0] p, input logic k);
		ctrl.send(p[6:0], k);
		{burst_active, full_page} = p[8:7];
		@(posedge core_clk);
		#1;
	endtask : cyc

	task automatic cmp_cmd(input logic v, input cmd_e c);
		tests_run++;
		if (cmd_valid !== v || cmd_code !== c) begin
			mismatches++;
			$display("unexpected at %0t: command %b %h", $time, cmd_valid, cmd_code);
		end
	endtask : cmp_cmd

	task automatic cmp_aux(input logic [1:0] b, input logic ap);
		tests_run++;
		if (cmd_bank !== b || cmd_auto_pre !== ap) begin
			mismatches++;
			$display("unexpected at %0t: bank %h auto-pre %b", $time, cmd_bank, cmd_auto_pre);
		end
	endtask : cmp_aux

	// x skips the clock gate where its timing is open
	task automatic cmp_state(input mode_e m, input logic e);
		tests_run++;
		if (mode !== m || bank_open !== bo || (e !== 1'bx && int_clk_en !== e)) begin
			mismatches++;
			$display("unexpected at %0t: state %h %b %b", $time, mode, int_clk_en, bank_open);
		end
	endtask : cmp_state

	task automatic step(input logic [8:0] p, input logic k, input logic v, input cmd_e c);
		cyc(p, k);
		cmp_cmd(v, c);
	endtask : step

	task automatic t_access;
		for (int i = 0; i < 4; i++) begin
			step(7'h18 | 7'(i), 1'b1, 1'b1, CMD_ACTIVATE);
			bo[i] = 1'b1;
			step(7'h18 | 7'(i), 1'b1, 1'b0, CMD_NOP);
			step({3'h2, i[0], i[1], 2'(i)}, 1'b1, 1'b1, cmd_e'({2'h1, i[0], i[1]}));
			cmp_aux(2'(i), i[1]);
			bo[i] = !i[1];
			cmp_state(ST_RUN, 1'b1);
		end
		step(7'h2a, 1'b1, 1'b0, CMD_NOP);
		step(7'h00, 1'b1, 1'b0, CMD_NOP);
		step(7'h08, 1'b1, 1'b0, CMD_NOP);
		step(7'h30, 1'b1, 1'b0, CMD_NOP);
		step(9'h1b8, 1'b1, 1'b0, CMD_NOP);
		step(9'h1b0, 1'b1, 1'b1, CMD_BURST_STOP);
		step(7'h10, 1'b1, 1'b1, CMD_PRECHARGE);
		bo = 4'h2;
		cmp_state(ST_RUN, 1'b1);
		step(7'h14, 1'b1, 1'b1, CMD_PRE_ALL);
		cmp_aux(2'h0, 1'b0);
		bo = 4'h0;
		step(7'h00, 1'b1, 1'b1, CMD_MODE_SET);
		step(7'h08, 1'b1, 1'b1, CMD_AUTO_REF);
		step(7'h40, 1'b1, 1'b0, CMD_NOP);
		step(7'h3f, 1'b1, 1'b0, CMD_NOP);
		cmp_state(ST_RUN, 1'b1);
		$display("test access done");
	endtask : t_access

	task automatic t_suspend;
		step(7'h1b, 1'b1, 1'b1, CMD_ACTIVATE);
		bo = 4'h8;
		cyc(7'h38, 1'b0);
		cmp_state(ST_SUSPEND, 1'b1);
		step(7'h18, 1'b0, 1'b0, CMD_NOP);
		cmp_state(ST_SUSPEND, 1'b0);
		step(7'h18, 1'b1, 1'b0, CMD_NOP);
		cmp_state(ST_RUN, 1'b0);
		cyc(7'h38, 1'b1);
		cmp_state(ST_RUN, 1'b1);
		step(7'h14, 1'b1, 1'b1, CMD_PRE_ALL);
		bo = 4'h0;
		cyc(9'h178, 1'b0);
		cmp_state(ST_SUSPEND, 1'b1);
		cyc(7'h78, 1'b1);
		cyc(7'h38, 1'b1);
		cmp_state(ST_RUN, 1'b1);
		$display("test suspend done");
	endtask : t_suspend

	task automatic t_sleep;
		cyc(7'h38, 1'b0);
		cmp_state(ST_POWER_DN, 1'b1);
		step(7'h40, 1'b0, 1'b0, CMD_NOP);
		cmp_state(ST_POWER_DN, 1'b0);
		cyc(7'h38, 1'b1);
		cmp_state(ST_RUN, 1'b0);
		cyc(7'h38, 1'b1); // nop after wake-up
		step(7'h08, 1'b0, 1'b1, CMD_SELF_REF);
		cmp_state(ST_SELF_REF, 1'b0);
		step(7'h00, 1'b0, 1'b0, CMD_NOP);
		cmp_state(ST_SELF_REF, 1'b0);
		cyc(7'h38, 1'b1);
		cmp_state(ST_RUN, 1'b0);
		cyc(7'h38, 1'b1); // nop after wake-up
		cmp_state(ST_RUN, 1'b1);
		$display("test sleep done");
	endtask : t_sleep

	initial begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		arst_n = 1'b1;
		repeat (3) cyc(7'h38, 1'b1);
		cmp_state(ST_RUN, 1'b1);
		t_access();
		t_suspend();
		t_sleep();
		final_report();
	end
endmodule : test_sdram_command_decode
`default_nettype wire
